// ### rtl/isvm_map.vh
// Constants for the interrupt source to vector mapping block.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data.
`ifndef ISVM_MAP_VH
`define ISVM_MAP_VH

`define ISVM_NUM_IRQ 39
`define ISVM_NUM_VEC 32
`define ISVM_LOW_BITS 32
`define ISVM_HIGH_BITS 7
`define ISVM_NUM_PRIO 8
`define ISVM_AW 8

`define ISVM_OFF_FLAG_LO 8'h00
`define ISVM_OFF_FLAG_HI 8'h04
`define ISVM_OFF_EN_LO 8'h08
`define ISVM_OFF_EN_HI 8'h0C
`define ISVM_OFF_PRIO0 8'h10
`define ISVM_OFF_PRIO7 8'h2C
`define ISVM_OFF_VSTAT 8'h30
`define ISVM_OFF_ISTAT 8'h34
`define ISVM_OFF_IMASK 8'h38

`define ISVM_PRIO_MASK 32'h1F1F1F1F
`define ISVM_SLOT_W 8
`define ISVM_PRI_LSB 2
`define ISVM_SUB_LSB 0

`define ISVM_VS_VEC_LSB 0
`define ISVM_VS_PRI_LSB 8
`define ISVM_VS_SUB_LSB 12
`define ISVM_VS_VALID 16

`define ISVM_EV_W 2
`define ISVM_EV_VEC 0
`define ISVM_EV_FLAG 1

`define ISVM_GRP_BASE 4
`define ISVM_GRP_LEN 5
`define ISVM_GRP_VEC 4
`define ISVM_OFF_TIMER 0
`define ISVM_OFF_CAPE 1
`define ISVM_OFF_CAP 2
`define ISVM_OFF_CMP 3
`define ISVM_IRQ_ADC 28
`define ISVM_IRQ_CLKFAIL 29
`define ISVM_VEC_CLKFAIL 24
`define ISVM_IRQ_USB 35
`define ISVM_IRQ_SPI 36
`define ISVM_VEC_SPI 31

`define ISVM_RESP_OKAY 2'b00
`define ISVM_RESP_SLVERR 2'b10

`endif

// ### rtl/isvm_arb.v
// Picks the vector to present from pending vectors and priority words.
// Assumes pending bits and priority words come from flops in the parent.
`timescale 1ns/1ps
`include "isvm_map.vh"

module isvm_arb (
    // Pending vectors and priority words
    input wire [`ISVM_NUM_VEC-1:0] i_pend,
    input wire [`ISVM_NUM_PRIO*32-1:0] i_prio,
    // Selected vector
    output reg o_valid,
    output reg [4:0] o_vec,
    output reg [2:0] o_pri,
    output reg [1:0] o_sub
);

    integer v;
    reg [31:0] word;
    reg [4:0] score;
    reg [4:0] best;

    // A plain scan keeps the tie rule obvious at the cost of a long chain.
    always @* begin
        o_valid = 1'b0;
        o_vec = 5'h00;
        best = 5'h00;
        word = 32'h0;
        score = 5'h00;
        for (v = 0; v < `ISVM_NUM_VEC; v = v + 1) begin
            word = i_prio[(v / 4) * 32 +: 32];
            score = {word[(v % 4) * `ISVM_SLOT_W + `ISVM_PRI_LSB +: 3],
                     word[(v % 4) * `ISVM_SLOT_W + `ISVM_SUB_LSB +: 2]};
            if (i_pend[v] && (!o_valid || score > best)) begin
                o_valid = 1'b1;
                best = score;
                o_vec = v[4:0];
            end
        end
        o_pri = best[4:2];
        o_sub = best[1:0];
    end

endmodule

// ### rtl/isvm_ctrl.v
// Interrupt source to vector mapping with flag, enable and priority registers.
// Assumes requests come from logic on i_clk_sys and an AXI4-Lite master.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "isvm_map.vh"

module isvm_ctrl (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Peripheral requests
    input wire [`ISVM_NUM_IRQ-1:0] i_req,
    // AXI4-Lite write address
    input wire [`ISVM_AW-1:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    // AXI4-Lite read address
    input wire [`ISVM_AW-1:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    // Vector to the core
    output reg o_vec_valid,
    output reg [4:0] o_vec_num,
    output reg [2:0] o_vec_pri,
    output reg [1:0] o_vec_sub,
    // Interrupt
    output reg o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Source tables.

    function [4:0] vec_of;
        input integer n;
        integer u;
        integer k;
        integer r;
        begin
            u = (n - `ISVM_GRP_BASE) / `ISVM_GRP_LEN;
            k = (n - `ISVM_GRP_BASE) % `ISVM_GRP_LEN;
            if (n < `ISVM_GRP_BASE) begin
                r = n;
            end else if (n <= `ISVM_IRQ_ADC) begin
                if (k == `ISVM_OFF_TIMER) begin
                    r = u * `ISVM_GRP_VEC + `ISVM_GRP_BASE;
                end else if (k == `ISVM_OFF_CAPE || k == `ISVM_OFF_CAP) begin
                    r = u * `ISVM_GRP_VEC + `ISVM_GRP_BASE + 1;
                end else if (k == `ISVM_OFF_CMP) begin
                    r = u * `ISVM_GRP_VEC + `ISVM_GRP_BASE + 2;
                end else begin
                    r = u * `ISVM_GRP_VEC + `ISVM_GRP_BASE + 3;
                end
            end else if (n < `ISVM_IRQ_SPI) begin
                r = n - (`ISVM_IRQ_CLKFAIL - `ISVM_VEC_CLKFAIL);
            end else begin
                r = `ISVM_VEC_SPI;
            end
            vec_of = r[4:0];
        end
    endfunction

    function is_persist;
        input integer n;
        integer k;
        begin
            k = (n - `ISVM_GRP_BASE) % `ISVM_GRP_LEN;
            if (n > `ISVM_GRP_BASE && n < `ISVM_IRQ_ADC) begin
                is_persist = (k == `ISVM_OFF_CAPE) || (k == `ISVM_OFF_CAP);
            end else begin
                is_persist = (n == `ISVM_IRQ_ADC) ||
                             (n == `ISVM_IRQ_USB) ||
                             (n >= `ISVM_IRQ_SPI);
            end
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b * 8 +: 8] = data[b * 8 +: 8];
                end
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers.

    reg [`ISVM_NUM_IRQ-1:0] req_d_reg;
    reg [`ISVM_NUM_IRQ-1:0] flag_reg;
    reg [`ISVM_NUM_IRQ-1:0] flag_next;
    reg [`ISVM_NUM_IRQ-1:0] en_reg;
    reg [`ISVM_NUM_IRQ-1:0] en_next;
    reg [31:0] prio_reg [0:`ISVM_NUM_PRIO-1];
    reg [`ISVM_EV_W-1:0] istat_reg;
    reg [`ISVM_EV_W-1:0] istat_next;
    reg [`ISVM_EV_W-1:0] imask_reg;
    reg [`ISVM_EV_W-1:0] imask_next;
    reg [`ISVM_AW-1:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire [`ISVM_NUM_IRQ-1:0] req_set;
    wire [`ISVM_NUM_PRIO*32-1:0] prio_flat;
    reg [`ISVM_NUM_VEC-1:0] pend;
    wire arb_valid;
    wire [4:0] arb_vec;
    wire [2:0] arb_pri;
    wire [1:0] arb_sub;
    integer n;

    ////////////////////////////////////////////////////////////////////////////
    // Request capture.

    // Persistent sources follow the level so clearing does not stick while
    // the peripheral still asserts; the others set once per rising edge.
    genvar g;
    generate
        for (g = 0; g < `ISVM_NUM_IRQ; g = g + 1) begin : gen_src
            assign req_set[g] = is_persist(g) ? i_req[g] :
                                (i_req[g] & ~req_d_reg[g]);
        end
        for (g = 0; g < `ISVM_NUM_PRIO; g = g + 1) begin : gen_prio
            assign prio_flat[g * 32 +: 32] = prio_reg[g];
        end
    endgenerate

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            req_d_reg <= {`ISVM_NUM_IRQ{1'b0}};
        end else begin
            req_d_reg <= i_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channel.

    wire wr_en = ~o_s_axi_awready & ~o_s_axi_wready & ~o_s_axi_bvalid;
    wire [`ISVM_AW-1:0] wa = {aw_addr_reg[`ISVM_AW-1:2], 2'b00};
    wire [`ISVM_AW-1:0] wa_rel = wa - `ISVM_OFF_PRIO0;
    wire wa_prio = (wa >= `ISVM_OFF_PRIO0) && (wa <= `ISVM_OFF_PRIO7);
    wire wa_hit = wa_prio || (wa == `ISVM_OFF_FLAG_LO) ||
                  (wa == `ISVM_OFF_FLAG_HI) || (wa == `ISVM_OFF_EN_LO) ||
                  (wa == `ISVM_OFF_EN_HI) || (wa == `ISVM_OFF_VSTAT) ||
                  (wa == `ISVM_OFF_ISTAT) || (wa == `ISVM_OFF_IMASK);

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `ISVM_RESP_OKAY;
            aw_addr_reg <= {`ISVM_AW{1'b0}};
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
        end else begin
            if (o_s_axi_awready && i_s_axi_awvalid) begin
                aw_addr_reg <= i_s_axi_awaddr;
                o_s_axi_awready <= 1'b0;
            end
            if (o_s_axi_wready && i_s_axi_wvalid) begin
                w_data_reg <= i_s_axi_wdata;
                w_strb_reg <= i_s_axi_wstrb;
                o_s_axi_wready <= 1'b0;
            end
            if (wr_en) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wa_hit ? `ISVM_RESP_OKAY : `ISVM_RESP_SLVERR;
            end
            if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
                o_s_axi_awready <= 1'b1;
                o_s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag, enable and priority storage.

    wire rd_take = o_s_axi_arready & i_s_axi_arvalid;
    wire [`ISVM_AW-1:0] ra = {i_s_axi_araddr[`ISVM_AW-1:2], 2'b00};
    wire [31:0] flag_hi_word = merge({25'h0, flag_reg[`ISVM_NUM_IRQ-1:32]},
                                     w_data_reg, w_strb_reg);
    wire [31:0] en_hi_word = merge({25'h0, en_reg[`ISVM_NUM_IRQ-1:32]},
                                   w_data_reg, w_strb_reg);
    wire [`ISVM_EV_W-1:0] events;

    // A hardware set wins over a software write in the same cycle.
    always @* begin
        flag_next = flag_reg;
        en_next = en_reg;
        if (wr_en && wa == `ISVM_OFF_FLAG_LO) begin
            flag_next[31:0] = merge(flag_reg[31:0], w_data_reg, w_strb_reg);
        end
        if (wr_en && wa == `ISVM_OFF_FLAG_HI) begin
            flag_next[`ISVM_NUM_IRQ-1:32] = flag_hi_word[`ISVM_HIGH_BITS-1:0];
        end
        if (wr_en && wa == `ISVM_OFF_EN_LO) begin
            en_next[31:0] = merge(en_reg[31:0], w_data_reg, w_strb_reg);
        end
        if (wr_en && wa == `ISVM_OFF_EN_HI) begin
            en_next[`ISVM_NUM_IRQ-1:32] = en_hi_word[`ISVM_HIGH_BITS-1:0];
        end
        flag_next = flag_next | req_set;
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            flag_reg <= {`ISVM_NUM_IRQ{1'b0}};
            en_reg <= {`ISVM_NUM_IRQ{1'b0}};
        end else begin
            flag_reg <= flag_next;
            en_reg <= en_next;
        end
    end

    generate
        for (g = 0; g < `ISVM_NUM_PRIO; g = g + 1) begin : gen_prio_reg
            always @(posedge i_clk_sys) begin
                if (i_rst) begin
                    prio_reg[g] <= 32'h0;
                end else if (wr_en && wa_prio && wa_rel[4:2] == g) begin
                    prio_reg[g] <= merge(prio_reg[g], w_data_reg, w_strb_reg) &
                                   `ISVM_PRIO_MASK;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Vector selection.

    // Shared vectors see the OR of their enabled sources.
    always @* begin
        pend = {`ISVM_NUM_VEC{1'b0}};
        for (n = 0; n < `ISVM_NUM_IRQ; n = n + 1) begin
            if (flag_reg[n] && en_reg[n]) begin
                pend[vec_of(n)] = 1'b1;
            end
        end
    end

    isvm_arb u_arb (
        .i_pend(pend),
        .i_prio(prio_flat),
        .o_valid(arb_valid),
        .o_vec(arb_vec),
        .o_pri(arb_pri),
        .o_sub(arb_sub)
    );

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_vec_valid <= 1'b0;
            o_vec_num <= 5'h00;
            o_vec_pri <= 3'h0;
            o_vec_sub <= 2'h0;
        end else begin
            o_vec_valid <= arb_valid;
            o_vec_num <= arb_vec;
            o_vec_pri <= arb_pri;
            o_vec_sub <= arb_sub;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask.

    assign events[`ISVM_EV_VEC] = arb_valid & (~o_vec_valid | (arb_vec != o_vec_num));
    assign events[`ISVM_EV_FLAG] = |(req_set & ~flag_reg);

    always @* begin
        istat_next = istat_reg;
        imask_next = imask_reg;
        if (rd_take && ra == `ISVM_OFF_ISTAT) begin
            istat_next = {`ISVM_EV_W{1'b0}};
        end
        istat_next = istat_next | events;
        if (wr_en && wa == `ISVM_OFF_IMASK) begin
            imask_next = w_strb_reg[0] ? w_data_reg[`ISVM_EV_W-1:0] : imask_reg;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            istat_reg <= {`ISVM_EV_W{1'b0}};
            imask_reg <= {`ISVM_EV_W{1'b0}};
            o_irq <= 1'b0;
        end else begin
            istat_reg <= istat_next;
            imask_reg <= imask_next;
            o_irq <= |(istat_next & imask_next);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel.

    wire [`ISVM_AW-1:0] ra_rel = ra - `ISVM_OFF_PRIO0;
    wire ra_prio = (ra >= `ISVM_OFF_PRIO0) && (ra <= `ISVM_OFF_PRIO7);
    reg [31:0] rd_mux;
    reg rd_hit;

    always @* begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        if (ra_prio) begin
            rd_mux = prio_reg[ra_rel[4:2]];
        end else begin
            case (ra)
                `ISVM_OFF_FLAG_LO: rd_mux = flag_reg[31:0];
                `ISVM_OFF_FLAG_HI: rd_mux = {25'h0, flag_reg[`ISVM_NUM_IRQ-1:32]};
                `ISVM_OFF_EN_LO: rd_mux = en_reg[31:0];
                `ISVM_OFF_EN_HI: rd_mux = {25'h0, en_reg[`ISVM_NUM_IRQ-1:32]};
                `ISVM_OFF_VSTAT: begin
                    rd_mux[`ISVM_VS_VEC_LSB +: 5] = o_vec_num;
                    rd_mux[`ISVM_VS_PRI_LSB +: 3] = o_vec_pri;
                    rd_mux[`ISVM_VS_SUB_LSB +: 2] = o_vec_sub;
                    rd_mux[`ISVM_VS_VALID] = o_vec_valid;
                end
                `ISVM_OFF_ISTAT: rd_mux[`ISVM_EV_W-1:0] = istat_reg;
                `ISVM_OFF_IMASK: rd_mux[`ISVM_EV_W-1:0] = imask_reg;
                default: rd_hit = 1'b0;
            endcase
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0;
            o_s_axi_rresp <= `ISVM_RESP_OKAY;
        end else begin
            if (rd_take) begin
                o_s_axi_arready <= 1'b0;
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= rd_mux;
                o_s_axi_rresp <= rd_hit ? `ISVM_RESP_OKAY : `ISVM_RESP_SLVERR;
            end
            if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
                o_s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ### tb/isvm_core_model.sv
// Behavioural core that receives the presented vector and the interrupt line.
// Assumes the vector outputs are registered on the same clock as this model.
`timescale 1ns/1ps

module isvm_core_model (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Vector and interrupt from the controller
    input wire i_vec_valid,
    input wire [4:0] i_vec_num,
    input wire i_irq,
    // Last vector taken and count of interrupt entries
    output logic [4:0] o_last_vec,
    output logic [15:0] o_entries
);
    logic irq_q;

    ////////////////////////////////////////
    // The vector is taken even while the line is masked, so that every source
    // still shows its mapping here; a real core would wait for the line.
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_last_vec <= 5'h00;
            o_entries <= 16'h0000;
            irq_q <= 1'b0;
        end else begin
            irq_q <= i_irq;
            if (i_vec_valid) begin
                o_last_vec <= i_vec_num;
            end
            if (i_irq && !irq_q) begin
                o_entries <= o_entries + 16'h0001;
            end
        end
    end
endmodule

// ### tb/isvm_ctrl_sva.sv
// Checker for the bus and vector ports of the mapping controller.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ps
`include "isvm_map.vh"

module isvm_ctrl_sva (
    // Clock and reset
    input wire i_clk_sys,
    input wire i_rst,
    // Bus signals
    input wire i_s_axi_awvalid,
    input wire o_s_axi_awready,
    input wire i_s_axi_wvalid,
    input wire o_s_axi_wready,
    input wire [1:0] o_s_axi_bresp,
    input wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [`ISVM_AW-1:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    input wire o_s_axi_arready,
    input wire [31:0] o_s_axi_rdata,
    input wire [1:0] o_s_axi_rresp,
    input wire o_s_axi_rvalid,
    input wire i_s_axi_rready,
    // Core side
    input wire o_vec_valid,
    input wire o_irq
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////
    reset_rest_a: assert property ($fell(i_rst) |-> !o_vec_valid && !o_irq && !o_s_axi_bvalid
        && !o_s_axi_rvalid && o_s_axi_awready && o_s_axi_arready)
        else $error("Outputs not at rest after reset.");
    aw_busy_a: assert property (i_s_axi_awvalid && o_s_axi_awready |=> !o_s_axi_awready)
        else $error("Write address ready stayed high after a take.");
    write_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("Write channels ready during a pending response.");
    write_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
        && o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid)
        else $error("Write response late.");
    b_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid
        && $stable(o_s_axi_bresp))
        else $error("Write response dropped or changed.");
    read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid
        && !o_s_axi_arready)
        else $error("Read data not presented one cycle after the address.");
    r_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid
        && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp))
        else $error("Read data dropped or changed.");
    r_release_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
        else $error("Read data held after its handshake.");
    rd_okay_a: assert property (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr < 8'h3C
        |=> o_s_axi_rresp == `ISVM_RESP_OKAY)
        else $error("Mapped read refused.");
    rd_refuse_a: assert property (i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr > 8'h3B
        |=> o_s_axi_rresp == `ISVM_RESP_SLVERR && o_s_axi_rdata == 32'h0)
        else $error("Unmapped read not refused.");

    cover property (o_s_axi_bvalid && i_s_axi_bready);
    cover property (o_s_axi_rvalid && o_s_axi_rresp == `ISVM_RESP_SLVERR);
    cover property ($rose(o_irq));
    cover property ($rose(o_vec_valid));
endmodule

bind isvm_ctrl isvm_ctrl_sva chk_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
    .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
    .o_s_axi_bresp(o_s_axi_bresp), .o_s_axi_bvalid(o_s_axi_bvalid),
    .i_s_axi_bready(i_s_axi_bready), .i_s_axi_araddr(i_s_axi_araddr),
    .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rdata(o_s_axi_rdata), .o_s_axi_rresp(o_s_axi_rresp),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
    .o_vec_valid(o_vec_valid), .o_irq(o_irq));

// ### tb/interrupt_source_vector_map_tb_top.sv
// Self-checking bench for the interrupt source to vector mapping controller.
// Assumes the controller, its bound checker and a core model on one 100 MHz clock.
`timescale 1ns/1ps
`include "isvm_map.vh"
`define ISVM_CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin bad_count++; \
$display("[ERR] %s expected %h seen %h", nm, e, s); end end

module interrupt_source_vector_map_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [38:0] req = 39'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdq;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [1:0] bq, rq;
    wire awready, wready, bvalid, arready, rvalid, vvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [4:0] vnum, last_vec;
    wire [2:0] vpri;
    wire [1:0] vsub;
    wire [15:0] entries;
    logic [127:0] fe;
    logic [31:0] pw [8];
    logic [38:0] pers = 39'h7816318C60;
    int vmap [39] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 9, 10, 11, 12, 13, 13, 14, 15, 16, 17, 17,
        18, 19, 20, 21, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30, 31, 31, 31};
    int bad_count = 0, compares = 0, cyc = 0;
    logic [10:0] p;
    logic [15:0] e0;

    always #5 clk = ~clk;

    isvm_ctrl dut_u (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_s_axi_awaddr(awaddr),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
        .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready), .o_vec_valid(vvalid), .o_vec_num(vnum), .o_vec_pri(vpri),
        .o_vec_sub(vsub), .o_irq(irq));

    isvm_core_model core_u (.i_clk_sys(clk), .i_rst(rst), .i_vec_valid(vvalid),
        .i_vec_num(vnum), .i_irq(irq), .o_last_vec(last_vec), .o_entries(entries));

    ////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    // Both channels are offered together; each is released at its own take.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            ad = ad | awready;
            wd = wd | wready;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        do @(posedge clk); while (!bvalid);
        bq = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rdq = rdata;
        rq = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `ISVM_CHK("rdata", e, rdq)
    endtask

    // Reference arbiter: strict greater-than keeps the lower vector on a tie.
    function automatic logic [10:0] pick();
        logic [4:0] key;
        int best;
        pick = 11'h000;
        best = -1;
        for (int n = 0; n < 39; n++) begin
            key = pw[vmap[n] / 4][8 * (vmap[n] % 4) +: 5];
            if (fe[n] && fe[64 + n] && int'(key) > best) begin
                best = key;
                pick = {1'b1, vmap[n][4:0], key};
            end
        end
    endfunction

    ////////////////////////////////////////
    initial begin
        void'($urandom(94911));
        foreach (pw[k]) pw[k] = 32'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 60; a += 4) rchk(8'(a), 32'h0);
        $display("test reset done");
        wr(8'h08, 32'hFFFFFFFF);
        wr(8'h0C, 32'h0000007F);
        for (int n = 0; n < 39; n++) begin
            fe = {25'h0, 39'h7FFFFFFFFF, 64'h0};
            fe[n] = 1'b1;
            req[n] <= 1'b1;
            repeat (4) @(posedge clk);
            p = pick();
            `ISVM_CHK("vector", p, {vvalid, vnum, vpri, vsub})
            `ISVM_CHK("core", vmap[n][4:0], last_vec)
            rchk(8'(n / 32 * 4), 32'h1 << (n % 32));
            wr(8'(n / 32 * 4), 32'h0);
            rchk(8'(n / 32 * 4), pers[n] ? 32'h1 << (n % 32) : 32'h0);
            req[n] <= 1'b0;
            wr(8'(n / 32 * 4), 32'h0);
        end
        $display("test map done");
        for (int it = 0; it < 12; it++) begin
            fe = {$urandom, $urandom, $urandom & $urandom, $urandom & $urandom};
            fe = fe & {25'h0, 39'h7FFFFFFFFF, 25'h0, 39'h7FFFFFFFFF};
            for (int k = 0; k < 4; k++) wr(8'(4 * k), fe[32 * k +: 32]);
            for (int k = 0; k < 8; k++) begin
                pw[k] = $urandom;
                wr(8'(16 + 4 * k), pw[k]);
                pw[k] = pw[k] & `ISVM_PRIO_MASK;
            end
            repeat (2) @(posedge clk);
            p = pick();
            `ISVM_CHK("vector", p, vvalid ? {vvalid, vnum, vpri, vsub} : 11'h000)
            if (p[10]) rchk(8'h30, {15'h0, p[10], 2'b00, p[1:0], 1'b0, p[4:2], 3'b000, p[9:5]});
            rchk(8'(16 + 4 * (it % 8)), pw[it % 8]);
            rchk(8'h04, fe[63:32]);
        end
        $display("test priority done");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h00000001);
        rd(8'h34);
        wr(8'h38, 32'h00000003);
        rchk(8'h38, 32'h00000003);
        e0 = entries;
        req[0] <= 1'b1;
        repeat (3) @(posedge clk);
        `ISVM_CHK("irq", 1'b1, irq)
        `ISVM_CHK("entries", e0 + 16'h0001, entries)
        rchk(8'h34, 32'h00000003);
        repeat (2) @(posedge clk);
        `ISVM_CHK("irq", 1'b0, irq)
        req[0] <= 1'b0;
        wr(8'h38, 32'h0);
        wr(8'h00, 32'h0);
        rd(8'h34);
        req[0] <= 1'b1;
        repeat (3) @(posedge clk);
        `ISVM_CHK("irq", 1'b0, irq)
        rchk(8'h34, 32'h00000003);
        req[0] <= 1'b0;
        $display("test interrupt done");
        wr(8'h3C, 32'hFFFFFFFF);
        `ISVM_CHK("bresp", `ISVM_RESP_SLVERR, bq)
        wr(8'h34, 32'hFFFFFFFF);
        `ISVM_CHK("bresp", `ISVM_RESP_OKAY, bq)
        rd(8'h40);
        `ISVM_CHK("rresp", `ISVM_RESP_SLVERR, rq)
        `ISVM_CHK("rdata", 32'h0, rdq)
        wstrb <= 4'h2;
        wr(8'h10, 32'hFFFFFFFF);
        wr(8'h38, 32'h00000003);
        wstrb <= 4'hF;
        rchk(8'h10, pw[0] | 32'h00001F00);
        rchk(8'h38, 32'h0);
        $display("test refusal done");
        end_of_test();
    end
endmodule
